// ### verilog/spp_prot.sv
// sector and password protection: serial command front end and lock state
// assumes the host holds sclk still while cs_n is high, and leaves cs_n high
// for at least 8 core clocks between frames; por_n also pulses rstn
`timescale 1ns/1ps
`default_nettype none

module spp_prot
  import spp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [7:0] pe_adr,
  output logic pe_allow,
  output logic cmd_done,
  output logic cmd_rej
);

  // link side state
  logic [6:0] cnt_q;
  logic [6:0] len_q;
  logic [7:0] cmd_q;
  logic [63:0] arg_q;
  logic tog_q;
  logic [63:0] tx_q;
  logic miso_q;
  logic oe_q;
  logic [63:0] rsp;
  logic is_rd;
  logic [6:0] rsp_at;

  // core side state
  logic cs_s;
  logic tog_s;
  logic seen_q;
  logic [1:0] mode_q;
  logic [63:0] pwd_q;
  logic [SPP_NSECT-1:0] nvl_q;
  logic [2*SPP_NVLK-1:0] vl_q;
  logic frz_q;
  logic init_q;
  logic done_q;
  logic rej_q;
  logic allow_q;
  logic go;
  logic len_ok;
  logic acc;
  logic ex;
  logic pwd_hit;
  logic w2;
  logic w1;
  logic [5:0] vix;
  logic [5:0] pix;
  logic [15:0] mode_rd;
  logic [7:0] frz_rd;
  logic [7:0] adr;
  logic [7:0] vadr;
  logic [1:0] vdat;

  assign adr = arg_q[7:0];
  assign mode_rd = {SPP_MODE_RSVD, mode_q, 1'b1};
  assign frz_rd = {SPP_FRZ_RSVD, frz_q};
  assign miso = miso_q;
  assign miso_oe = oe_q;
  assign pe_allow = allow_q;
  assign cmd_done = done_q;
  assign cmd_rej = rej_q;

  // bit counter of the frame, ended by the frame's own select
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= '0;
    end else if (cnt_q != SPP_CNT_MAX) begin
      cnt_q <= cnt_q + 7'd1;
    end
  end

  // shift in command and argument, mark each new frame with a toggle
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
      arg_q <= '0;
      len_q <= '0;
      tog_q <= 1'b0;
    end else begin
      len_q <= (cnt_q == SPP_CNT_MAX) ? cnt_q : cnt_q + 7'd1;
      if (cnt_q == 7'd0) begin
        tog_q <= ~tog_q;
      end
      if (cnt_q < SPP_LEN_CMD) begin
        cmd_q <= {cmd_q[6:0], mosi};
      end else begin
        arg_q <= {arg_q[62:0], mosi};
      end
    end
  end

  // read answers, from core state that only moves between frames
  always_comb begin
    rsp = '0;
    is_rd = spp_is_rd(cmd_q);
    rsp_at = SPP_LEN_CMD;
    case (spp_cmd_t'(cmd_q))
      SPP_RD_MODE: rsp = {mode_rd, 48'h0};
      SPP_RD_PWD: rsp = mode_q[1] ? pwd_q : SPP_PWD_RST;
      SPP_RD_FRZ: rsp = {frz_rd, 56'h0};
      SPP_RD_NVL: begin
        rsp = {7'h00, nvl_q[adr[7:4]], 56'h0};
        rsp_at = SPP_LEN_ADR;
      end
      SPP_RD_VL: begin
        rsp = {6'h00, vl_q[2*spp_vl_idx(adr) +: 2], 56'h0};
        rsp_at = SPP_LEN_ADR;
      end
      default: rsp = '0;
    endcase
  end

  // answer shifts out msb first on falling edges
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      tx_q <= '0;
      miso_q <= 1'b0;
    end else if (is_rd && cnt_q == rsp_at) begin
      tx_q <= {rsp[62:0], 1'b0};
      miso_q <= rsp[63];
    end else begin
      tx_q <= {tx_q[62:0], 1'b0};
      miso_q <= tx_q[63];
    end
  end

  // output enable from answer start to end of frame
  always_ff @(negedge sclk or posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      oe_q <= 1'b0;
    end else if (cs_n) begin
      oe_q <= 1'b0;
    end else if (is_rd && cnt_q == rsp_at) begin
      oe_q <= 1'b1;
    end
  end

  // bring select level and frame toggle into the core clock
  spp_sync3 #(
    .W(2)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din({cs_n, tog_q}),
    .dout_q({cs_s, tog_s})
  );

  // a finished frame runs once, after the select has gone high
  assign go = cs_s && (tog_s != seen_q);
  assign pwd_hit = (arg_q == pwd_q);
  assign w2 = ~arg_q[2];
  assign w1 = ~arg_q[1];
  assign vadr = arg_q[15:8]; // volatile write: address byte comes first
  assign vdat = arg_q[1:0]; // then the data byte
  assign vix = spp_vl_idx(vadr);
  assign pix = spp_vl_idx(pe_adr);
  assign len_ok = spp_is_rd(cmd_q) ? (len_q >= spp_cmd_len(cmd_q)) : (len_q == spp_cmd_len(cmd_q));
  assign ex = go && len_ok && acc;

  // which commands the present state lets through
  always_comb begin
    acc = 1'b0;
    case (spp_cmd_t'(cmd_q))
      SPP_RD_MODE, SPP_RD_PWD, SPP_RD_FRZ, SPP_RD_NVL, SPP_RD_VL: acc = 1'b1;
      SPP_WR_MODE: acc = !(w2 && w1) && (!w2 || mode_q[0]) && (!w1 || mode_q[1]);
      SPP_WR_PWD: acc = mode_q[1];
      SPP_UNLOCK: acc = pwd_hit;
      SPP_WR_FRZ, SPP_SWRST: acc = 1'b1;
      SPP_WR_NVL, SPP_ER_NVL: acc = frz_q;
      SPP_WR_VL: acc = !vl_q[2*vix+SPP_VLK_LD];
      default: acc = 1'b0;
    endcase
  end

  // frame bookkeeping and result pulses
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
      done_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      done_q <= go;
      rej_q <= go && !(len_ok && acc);
      if (go) begin
        seen_q <= tog_s;
      end
    end
  end

  // one-time mode bits, cleared only, never both
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      mode_q <= SPP_MODE_RST;
    end else if (ex && cmd_q == SPP_WR_MODE) begin
      if (w2) begin
        mode_q[1] <= 1'b0;
      end
      if (w1) begin
        mode_q[0] <= 1'b0;
      end
    end
  end

  // password store, writable only outside password mode
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      pwd_q <= SPP_PWD_RST;
    end else if (ex && cmd_q == SPP_WR_PWD) begin
      pwd_q <= arg_q;
    end
  end

  // nonvolatile sector locks, delivered open
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      nvl_q <= SPP_NVL_RST;
    end else if (ex && cmd_q == SPP_ER_NVL) begin
      nvl_q <= SPP_NVL_RST;
    end else if (ex && cmd_q == SPP_WR_NVL) begin
      nvl_q[adr[7:4]] <= 1'b0;
    end
  end

  // volatile locks, cleared by hardware or software reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vl_q <= SPP_VL_RST;
    end else if (ex && cmd_q == SPP_SWRST) begin
      vl_q <= SPP_VL_RST;
    end else if (ex && cmd_q == SPP_WR_VL) begin
      vl_q[2*vix +: 2] <= vdat;
    end
  end

  // freeze bit: taken from the mode after reset, then by command
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frz_q <= 1'b0;
      init_q <= 1'b0;
    end else if (!init_q || (ex && cmd_q == SPP_SWRST)) begin
      frz_q <= mode_q[1];
      init_q <= 1'b1;
    end else if (ex && cmd_q == SPP_UNLOCK) begin
      frz_q <= 1'b1;
    end else if (ex && cmd_q == SPP_WR_FRZ) begin
      frz_q <= 1'b0;
    end
  end

  // program and erase gate for the array
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      allow_q <= 1'b0;
    end else begin
      allow_q <= nvl_q[pe_adr[7:4]] && !vl_q[2*pix+SPP_VLK_WL];
    end
  end

  // checks, all on the core clock
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_unlock_ok;
    go && len_ok && cmd_q == SPP_UNLOCK && pwd_hit;
  endsequence

  sequence s_plain_cycle;
    init_q && !(ex && cmd_q == SPP_SWRST);
  endsequence

  a_mode_exclusive: assert property (disable iff (!por_n) mode_q != 2'b00)
    else $error("both mode bits cleared");

  a_mode_once: assert property (disable iff (!por_n) !mode_q[1] |=> !mode_q[1] && mode_q[0])
    else $error("password mode bit came back");

  a_nopwd_mode: assert property (disable iff (!por_n) !mode_q[0] |=> mode_q[1] && !mode_q[0])
    else $error("no-password mode broke");

  a_pwd_frozen: assert property (!mode_q[1] |=> $stable(pwd_q))
    else $error("password changed in password mode");

  a_frz_boot: assert property ($rose(init_q) |-> frz_q == $past(mode_q[1]))
    else $error("freeze wrong after reset");

  a_unlock_sets: assert property (s_plain_cycle and s_unlock_ok |=> frz_q && cmd_done && !cmd_rej)
    else $error("unlock did not set freeze");

  a_frz_held: assert property (s_plain_cycle and !frz_q and !(ex && cmd_q == SPP_UNLOCK) |=> !frz_q)
    else $error("freeze rose without password");

  a_bad_pwd: assert property (go && cmd_q == SPP_UNLOCK && !pwd_hit |=> cmd_rej)
    else $error("wrong password accepted");

  a_nvl_guard: assert property (!frz_q |=> $stable(nvl_q))
    else $error("locks changed while frozen");

  a_set_freeze: assert property (s_plain_cycle and go && len_ok && cmd_q == SPP_WR_FRZ |=> !frz_q)
    else $error("set-freeze missed");

  a_vl_lockdown: assert property (go && cmd_q == SPP_WR_VL && vl_q[2*vix+SPP_VLK_LD] |=> $stable(vl_q) && cmd_rej)
    else $error("locked-down entry written");

  a_pe_block: assert property (!nvl_q[pe_adr[7:4]] || vl_q[2*pix+SPP_VLK_WL] |=> !pe_allow)
    else $error("protected target allowed");

  a_frame_once: assert property (go |=> !go ##1 cmd_done == 1'b0)
    else $error("frame ran twice");

  // results, erase and reset follow the executed frame, the gate follows the lock state
  a_rej_done: assert property (cmd_rej |-> cmd_done)
    else $error("refusal without completion");

  a_done_follow: assert property (go |=> cmd_done)
    else $error("frame not completed");

  a_nvl_erase: assert property (ex && cmd_q == SPP_ER_NVL |=> nvl_q == SPP_NVL_RST)
    else $error("lock erase incomplete");

  a_vl_swreset: assert property (ex && cmd_q == SPP_SWRST |=> vl_q == SPP_VL_RST)
    else $error("volatile locks kept after soft reset");

  a_pe_open: assert property (nvl_q[pe_adr[7:4]] && !vl_q[2*pix+SPP_VLK_WL] |=> pe_allow)
    else $error("open target refused");

  a_pwd_store: assert property (ex && cmd_q == SPP_WR_PWD |=> pwd_q == $past(arg_q))
    else $error("password write lost");

endmodule

`default_nettype wire

// ### verilog/spp_pkg.sv
// constants, command codes and helpers of the sector and password protection logic
// assumes one serial link (clock, select, data in, data out) and one core clock

package spp_pkg;

  localparam int SPP_NSECT = 16;
  localparam int SPP_NSUB = 16;
  localparam int SPP_NVLK = 2 * SPP_NSUB + SPP_NSECT - 2;
  localparam logic [1:0] SPP_MODE_RST = 2'b11;
  localparam logic [63:0] SPP_PWD_RST = 64'hffff_ffff_ffff_ffff;
  localparam logic [SPP_NSECT-1:0] SPP_NVL_RST = {SPP_NSECT{1'b1}};
  localparam logic [2*SPP_NVLK-1:0] SPP_VL_RST = '0;
  localparam logic [12:0] SPP_MODE_RSVD = 13'h1fff;
  localparam logic [6:0] SPP_FRZ_RSVD = 7'h00;
  localparam int SPP_VLK_WL = 0;
  localparam int SPP_VLK_LD = 1;
  localparam logic [6:0] SPP_CNT_MAX = 7'h7f;
  localparam logic [6:0] SPP_LEN_CMD = 7'h08;
  localparam logic [6:0] SPP_LEN_ADR = 7'h10;
  localparam logic [6:0] SPP_LEN_B2 = 7'h18;
  localparam logic [6:0] SPP_LEN_PWD = 7'h48;

  typedef enum logic [7:0] {
    SPP_RD_MODE = 8'h10,
    SPP_WR_MODE = 8'h11,
    SPP_RD_PWD = 8'h12,
    SPP_WR_PWD = 8'h13,
    SPP_UNLOCK = 8'h14,
    SPP_RD_FRZ = 8'h15,
    SPP_WR_FRZ = 8'h16,
    SPP_RD_NVL = 8'h17,
    SPP_WR_NVL = 8'h18,
    SPP_ER_NVL = 8'h19,
    SPP_RD_VL = 8'h1a,
    SPP_WR_VL = 8'h1b,
    SPP_SWRST = 8'h1c
  } spp_cmd_t;

  // volatile lock slot: subsectors of first and last sector, then whole sectors
  function automatic logic [5:0] spp_vl_idx(input logic [7:0] adr);
    logic [5:0] i;
    i = 6'(adr[7:4]) + 6'd31;
    if (adr[7:4] == 4'h0) begin
      i = {2'b00, adr[3:0]};
    end else if (adr[7:4] == 4'hf) begin
      i = {2'b01, adr[3:0]};
    end
    return i;
  endfunction

  // frame length: exact for writes, least for reads, 0 for unknown codes
  function automatic logic [6:0] spp_cmd_len(input logic [7:0] c);
    logic [6:0] n;
    n = 7'h00;
    case (spp_cmd_t'(c))
      SPP_RD_MODE, SPP_RD_PWD, SPP_RD_FRZ, SPP_WR_FRZ, SPP_ER_NVL, SPP_SWRST: n = SPP_LEN_CMD;
      SPP_RD_NVL, SPP_RD_VL, SPP_WR_NVL: n = SPP_LEN_ADR;
      SPP_WR_MODE, SPP_WR_VL: n = SPP_LEN_B2;
      SPP_WR_PWD, SPP_UNLOCK: n = SPP_LEN_PWD;
      default: n = 7'h00;
    endcase
    return n;
  endfunction

  function automatic logic spp_is_rd(input logic [7:0] c);
    return c == SPP_RD_MODE || c == SPP_RD_PWD || c == SPP_RD_FRZ || c == SPP_RD_NVL || c == SPP_RD_VL;
  endfunction

endpackage

// ### verilog/spp_sync3.sv
// three-stage synchroniser; a change passes once stages two and three agree
// assumes the input is quasi-static against the core clock
`timescale 1ns/1ps
`default_nettype none

module spp_sync3 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output var logic [W-1:0] dout_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stage one feeds stage two only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept the level when the last two stages agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dout_q <= '0;
    end else if (s2_q == s3_q) begin
      dout_q <= s3_q;
    end
  end

endmodule

`default_nettype wire

// ### tb/spp_host.sv
// host model: drives serial frames on the link, samples answer bits
// assumes the core pulses cmd_done once per frame on core_clk
`timescale 1ns/1ps
`default_nettype none

module spp_host (
  input wire logic core_clk,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic cmd_done,
  input wire logic cmd_rej,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  logic last;

  // idle link: clock still, frame deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
  end

  // one frame of n bits, msb first; w is left aligned, r holds the last bits seen
  task automatic frame(input int n, input logic [71:0] w, output logic [71:0] r,
                       output logic done, output logic rej);
    int i;
    r = '0;
    done = 1'b0;
    rej = 1'b0;
    #3.3 cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      mosi = w[71-i];
      #62.5 sclk = 1'b1;
      r = {r[70:0], miso_oe ? miso : ~last}; // undriven line shows no stale bit
      last = r[0];
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    mosi = ~mosi;
    // bounded wait for the completion pulse, then the inter-frame gap
    for (i = 0; i < 40 && !done; i++) begin
      @(posedge core_clk);
      #1;
      if (cmd_done === 1'b1) begin
        done = 1'b1;
        rej = cmd_rej;
      end
    end
    repeat (10) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// ### tb/spp_prot_tb.sv
// self-checking bench of the protection block with a serial host model
// assumes por_n and rstn asynchronous, frames at a 125 ns link clock
`timescale 1ns/1ps
`default_nettype none

module spp_prot_tb;
  import spp_pkg::*;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  logic [7:0] pe_adr = 8'h00;
  logic sclk, cs_n, mosi, miso, miso_oe, pe_allow, cmd_done, cmd_rej;
  int fail_count = 0;
  int cmp_count = 0;
  logic [63:0] pw = 64'h0123_4567_89ab_cdef;

  // core clock at 125 MHz
  always #4 core_clk = ~core_clk;

  spp_prot i_spp_prot (.core_clk(core_clk), .rstn(rstn), .por_n(por_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .pe_adr(pe_adr),
    .pe_allow(pe_allow), .cmd_done(cmd_done), .cmd_rej(cmd_rej));

  spp_host i_spp_host (.core_clk(core_clk), .miso(miso), .miso_oe(miso_oe),
    .cmd_done(cmd_done), .cmd_rej(cmd_rej), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // reset held 3 cycles; por also restores delivered nonvolatile state
  task automatic do_reset(input logic por);
    @(negedge core_clk);
    rstn = 1'b0;
    por_n = ~por;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    por_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask

  // frame with completion and refusal checks; a missing pulse ends the run
  task automatic cmd(input int n, input logic [71:0] w, input logic erej,
                     output logic [71:0] r);
    logic d, j;
    i_spp_host.frame(n, w, r, d, j);
    chk(64'(d), 64'h1);
    if (d !== 1'b1) begin
      conclude();
    end
    chk(64'(j), 64'(erej));
  endtask

  // read frame of n bits whose last k bits are the answer
  task automatic rd(input int n, input logic [71:0] w, input int k, input logic [63:0] e);
    logic [71:0] r;
    cmd(n, w, 1'b0, r);
    chk(r[63:0] & ~(64'hffff_ffff_ffff_ffff << k), e);
  endtask

  task automatic wr(input int n, input logic [71:0] w, input logic erej);
    logic [71:0] r;
    cmd(n, w, erej, r);
  endtask

  // array target protection checked two core clocks after the address is set
  task automatic pe(input logic [7:0] a, input logic e);
    @(negedge core_clk);
    pe_adr = a;
    repeat (2) @(negedge core_clk);
    chk(64'(pe_allow), 64'(e));
  endtask

  task automatic t_delivered();
    do_reset(1'b1);
    rd(24, {SPP_RD_MODE, 64'h0}, 16, 64'hffff);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h01);
    rd(24, {SPP_RD_NVL, 8'h30, 56'h0}, 8, 64'h01);
    rd(24, {SPP_RD_VL, 8'h02, 56'h0}, 8, 64'h00);
    pe(8'h31, 1'b1);
    wr(8, {8'h00, 64'h0}, 1'b1);
    $display("test delivered done");
  endtask

  task automatic t_locks();
    wr(16, {SPP_WR_NVL, 8'h90, 56'h0}, 1'b0);
    pe(8'h95, 1'b0);
    wr(8, {SPP_WR_FRZ, 64'h0}, 1'b0);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h00);
    wr(8, {SPP_ER_NVL, 64'h0}, 1'b1);
    pe(8'h95, 1'b0);
    wr(72, {SPP_UNLOCK, 64'hffff_ffff_ffff_ffff}, 1'b0);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h01);
    wr(8, {SPP_ER_NVL, 64'h0}, 1'b0);
    pe(8'h95, 1'b1);
    wr(24, {SPP_WR_VL, 8'h02, 8'h01, 48'h0}, 1'b0);
    pe(8'h02, 1'b0);
    pe(8'h03, 1'b1);
    wr(24, {SPP_WR_VL, 8'h50, 8'h03, 48'h0}, 1'b0);
    wr(24, {SPP_WR_VL, 8'h50, 8'h00, 48'h0}, 1'b1);
    pe(8'h57, 1'b0);
    wr(8, {SPP_SWRST, 64'h0}, 1'b0);
    pe(8'h02, 1'b1);
    pe(8'h57, 1'b1);
    $display("test locks done");
  endtask

  task automatic t_password();
    wr(72, {SPP_WR_PWD, pw}, 1'b0);
    rd(72, {SPP_RD_PWD, 64'h0}, 64, pw);
    wr(24, {SPP_WR_MODE, 16'hfff9, 48'h0}, 1'b1);
    wr(24, {SPP_WR_MODE, 16'hfffb, 48'h0}, 1'b0);
    rd(24, {SPP_RD_MODE, 64'h0}, 16, 64'hfffb);
    rd(72, {SPP_RD_PWD, 64'h0}, 64, 64'hffff_ffff_ffff_ffff);
    wr(72, {SPP_WR_PWD, 64'h0}, 1'b1);
    wr(24, {SPP_WR_MODE, 16'hfffd, 48'h0}, 1'b1);
    do_reset(1'b0);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h00);
    wr(72, {SPP_UNLOCK, ~pw}, 1'b1);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h00);
    wr(16, {SPP_WR_NVL, 8'h30, 56'h0}, 1'b1);
    pe(8'h31, 1'b1);
    wr(72, {SPP_UNLOCK, pw}, 1'b0);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h01);
    wr(16, {SPP_WR_NVL, 8'h30, 56'h0}, 1'b0);
    pe(8'h31, 1'b0);
    $display("test password done");
  endtask

  // mode without password: bit 1 cleared, bit 2 then locked at 1
  task automatic t_nopwd();
    do_reset(1'b1);
    wr(24, {SPP_WR_MODE, 16'hfffd, 48'h0}, 1'b0);
    rd(24, {SPP_RD_MODE, 64'h0}, 16, 64'hfffd);
    wr(24, {SPP_WR_MODE, 16'hfffb, 48'h0}, 1'b1);
    do_reset(1'b0);
    rd(16, {SPP_RD_FRZ, 64'h0}, 8, 64'h01);
    wr(16, {SPP_WR_NVL, 8'h70, 56'h0}, 1'b0);
    pe(8'h7a, 1'b0);
    $display("test no-password done");
  endtask

  // main sequence
  initial begin
    t_delivered();
    t_locks();
    t_password();
    t_nopwd();
    conclude();
  end
endmodule

`default_nettype wire
